// File: src/mic_top.sv
// Maskable interrupt control: AHB registers, arbitration, entry sequence
`timescale 1ns/1ps
`include "mic_params.svh"
module mic_top (
	input  wire logic        clk_sys_i,     // 40 MHz system clock
	input  wire logic        reset_i,       // Synchronous reset, high
	// AHB-Lite slave
	input  wire logic        hsel_i,        // Slave select
	input  wire logic [31:0] haddr_i,       // Byte address
	input  wire logic [1:0]  htrans_i,      // Transfer type
	input  wire logic        hwrite_i,      // Write not read
	input  wire logic [2:0]  hsize_i,       // Transfer size
	input  wire logic [31:0] hwdata_i,      // Write data
	input  wire logic        hready_i,      // Bus ready
	output logic             hreadyout_o,   // Slave ready
	output logic      [31:0] hrdata_o,      // Read data
	output logic             hresp_o,       // Always OKAY
	// Sources
	input  wire logic [4:0]  pin_i,         // Ext pins 0..4, async
	input  wire logic [4:0]  both_edge_i,   // Both-edge per pin
	input  wire logic [6:0]  multi_req_i,   // Multi-source levels
	// CPU core
	input  wire logic        instr_done_i,  // Instruction boundary
	input  wire logic        suspend_ok_i,  // String or repeat op running
	input  wire logic [7:0]  flag_i,        // Current flag register
	input  wire logic [2:0]  ipl_i,         // Current mask level
	input  wire logic        trap_i,        // Software trap request
	input  wire logic [5:0]  trap_num_i,    // Trap number
	input  wire logic [19:0] vec_addr_i,    // Routine start address
	output mic_pkg::mic_entry_s entry_o,    // Entry strobes
	output logic      [19:0] fetch_addr_o,  // Information address
	output logic      [5:0]  vec_num_o,     // Accepted number
	output logic      [7:0]  flag_o,        // Flags to push / update
	output logic      [2:0]  ipl_o,         // New mask level
	output logic      [19:0] pc_o,          // New program counter
	output logic             busy_o         // Entry in progress
);
	localparam int NS = `MIC_NSRC;
	// Source order is the fixed hardware order for equal levels
	localparam logic [7:0] IDX [NS] = '{`MIC_IDX_FLASH, `MIC_IDX_PIN4,
		`MIC_IDX_PWM, `MIC_IDX_SER0, `MIC_IDX_PIN2, `MIC_IDX_PIN1,
		`MIC_IDX_PIN3, `MIC_IDX_PIN0, `MIC_IDX_SENSOR, `MIC_IDX_SER1,
		`MIC_IDX_SER2, `MIC_IDX_SER3};
	// Pin number of each source, or none
	localparam logic [NS-1:0] IS_PIN = 12'h0f2;
	localparam int PIN_OF [NS] = '{0, 4, 0, 0, 2, 1, 3, 0, 0, 0, 0, 0};
	localparam int MUL_OF [NS] = '{0, 0, 1, 2, 0, 0, 0, 0, 3, 4, 5, 6};
	// Interrupt numbers per source; values are arbitrary defaults
	localparam logic [5:0] VNUM [NS] = '{6'h01, 6'h02, 6'h03, 6'h04,
		6'h05, 6'h06, 6'h07, 6'h1d, 6'h2a, 6'h38, 6'h39, 6'h3a};

	// Bus slave state
	logic        wr_pend_ff, nxt_wr_pend;   // Write data phase due
	logic [7:0]  wr_idx_ff,  nxt_wr_idx;    // Write register index
	logic        rd_wait_ff, nxt_rd_wait;   // Read wait state
	logic [7:0]  rd_idx_ff,  nxt_rd_idx;    // Read register index
	logic        hrdy_ff,    nxt_hrdy;      // Ready toward master
	logic [31:0] hrdata_ff,  nxt_hrdata;    // Read data
	logic        addr_ok;
	// Per-source wires
	logic [7:0]  ctrl_w [NS];
	logic [2:0]  lvl_w  [NS];
	logic [NS-1:0] pend_w, evt_w, wr_w, clr_w;
	// Sequencer state
	mic_pkg::mic_state_e st_ff, nxt_st;
	logic [4:0]  cnt_ff,  nxt_cnt;          // Cycle within entry
	logic [3:0]  win_ff,  nxt_win;          // Accepted source
	logic [2:0]  alvl_ff, nxt_alvl;         // Accepted level
	logic        trap_ff, nxt_trap;         // Entry is a trap
	logic [7:0]  tmp_ff,  nxt_tmp;          // Saved flag copy
	mic_pkg::mic_entry_s ent_ff, nxt_ent;
	logic [5:0]  num_ff,  nxt_num;
	logic [7:0]  flg_ff,  nxt_flg;
	logic [2:0]  ipl_ff,  nxt_ipl;
	logic [19:0] pc_ff,   nxt_pc;
	// Arbitration results
	logic [3:0]  best;
	logic [2:0]  best_lvl;
	logic        any_req, accept, boundary;

	// Address phase qualifier
	assign addr_ok = hsel_i && hready_i && htrans_i[1];

	// Bus slave next values: writes take no wait, reads one
	always_comb begin
		nxt_wr_pend = addr_ok && hwrite_i;
		nxt_wr_idx  = haddr_i[9:2];
		nxt_rd_wait = addr_ok && !hwrite_i;
		nxt_rd_idx  = rd_wait_ff ? rd_idx_ff : haddr_i[9:2];
		nxt_hrdy    = !nxt_rd_wait;
		nxt_hrdata  = hrdata_ff;
		if (rd_wait_ff) begin
			// Registers are current here, even after a write
			nxt_hrdata = `MIC_RD_ZERO;
			for (int i = 0; i < NS; i++) begin
				if (rd_idx_ff == IDX[i]) begin
					nxt_hrdata = {24'h0, ctrl_w[i]};
				end
			end
		end
	end

	// Bus slave registers
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff  <= 8'h00;
			rd_wait_ff <= 1'b0;
			rd_idx_ff  <= 8'h00;
			hrdy_ff    <= 1'b1;
			hrdata_ff  <= `MIC_RD_ZERO;
		end else begin
			wr_pend_ff <= nxt_wr_pend;
			wr_idx_ff  <= nxt_wr_idx;
			rd_wait_ff <= nxt_rd_wait;
			rd_idx_ff  <= nxt_rd_idx;
			hrdy_ff    <= nxt_hrdy;
			hrdata_ff  <= nxt_hrdata;
		end
	end

	assign hreadyout_o = hrdy_ff;
	assign hrdata_o    = hrdata_ff;
	assign hresp_o     = 1'b0;

	// One control block per source
	for (genvar g = 0; g < NS; g++) begin : g_src
		assign wr_w[g]  = wr_pend_ff && (wr_idx_ff == IDX[g]);
		assign clr_w[g] = accept && !trap_i && (best == 4'(g));
		mic_src_ctrl #(
			.IS_PIN (IS_PIN[g])
		) u_src (
			.clk_sys_i (clk_sys_i),
			.reset_i   (reset_i),
			.req_i     (IS_PIN[g] ? 1'b0 : multi_req_i[MUL_OF[g]]),
			.pin_i     (IS_PIN[g] ? pin_i[PIN_OF[g]] : 1'b0),
			.both_i    (IS_PIN[g] ? both_edge_i[PIN_OF[g]] : 1'b0),
			.wr_i      (wr_w[g]),
			.wdata_i   (hwdata_i[7:0]),
			.ack_clr_i (clr_w[g]),
			.ctrl_o    (ctrl_w[g]),
			.level_o   (lvl_w[g]),
			.pend_o    (pend_w[g]),
			.evt_o     (evt_w[g])
		);
	end

	// Highest level wins; earlier source wins a tie
	always_comb begin
		best     = 4'h0;
		best_lvl = `MIC_LVL_OFF;
		for (int i = 0; i < NS; i++) begin
			if (pend_w[i] && (lvl_w[i] > best_lvl)) begin // see [R23]
				best     = 4'(i);
				best_lvl = lvl_w[i]; // see [R1]
			end
		end
		// Flags are only read, never altered by the test
		any_req = flag_i[`MIC_FLG_I]
			&& (best_lvl != `MIC_LVL_OFF)
			&& (best_lvl > ipl_i); // see [R10] [R11] [R12] [R13]
	end

	// Boundary or a suspendable instruction lets entry start
	assign boundary = instr_done_i || suspend_ok_i; // see [R14] [R15]
	assign accept   = (st_ff == mic_pkg::MIC_IDLE) && boundary
		&& (any_req || trap_i);

	// Entry sequencer next values
	always_comb begin
		nxt_st   = st_ff;
		nxt_cnt  = cnt_ff;
		nxt_win  = win_ff;
		nxt_alvl = alvl_ff;
		nxt_trap = trap_ff;
		nxt_tmp  = tmp_ff;
		nxt_num  = num_ff;
		nxt_flg  = flg_ff;
		nxt_ipl  = ipl_ff;
		nxt_pc   = pc_ff;
		nxt_ent  = '0;
		case (st_ff)
			mic_pkg::MIC_IDLE: begin
				if (accept) begin
					// Trap takes precedence, keeps the mask level
					nxt_st    = mic_pkg::MIC_FETCH;
					nxt_cnt   = 5'h00;
					nxt_win   = best;
					nxt_alvl  = trap_i ? ipl_i : best_lvl;
					nxt_trap  = trap_i;
					nxt_num   = trap_i ? trap_num_i : VNUM[best];
					nxt_tmp   = flag_i; // see [R17]
					nxt_ent.fetch = 1'b1; // see [R16]
				end
			end
			mic_pkg::MIC_FETCH: begin
				nxt_cnt = cnt_ff + 5'h01;
				if (nxt_cnt == `MIC_STEP_PUSHF) begin
					nxt_st           = mic_pkg::MIC_SAVE;
					nxt_flg          = tmp_ff;
					nxt_ent.push_flg = 1'b1; // see [R17]
				end
			end
			mic_pkg::MIC_SAVE: begin
				nxt_cnt = cnt_ff + 5'h01;
				if (nxt_cnt == `MIC_STEP_PUSHPC) begin
					nxt_ent.push_pc = 1'b1; // see [R17]
				end
				if (nxt_cnt == `MIC_STEP_FLAGS) begin
					nxt_st  = mic_pkg::MIC_LOAD;
					nxt_flg = tmp_ff;
					nxt_flg[`MIC_FLG_I] = 1'b0; // see [R18]
					nxt_flg[`MIC_FLG_D] = 1'b0; // see [R18]
					if (!(trap_ff && num_ff >= `MIC_TRAP_LO)) begin
						nxt_flg[`MIC_FLG_U] = 1'b0; // see [R18] [R19]
					end
					nxt_ipl = alvl_ff; // see [R20]
					nxt_ent.flg_upd = 1'b1;
				end
			end
			mic_pkg::MIC_LOAD: begin
				nxt_cnt = cnt_ff + 5'h01;
				if (nxt_cnt == `MIC_STEP_LOADPC) begin
					nxt_st  = mic_pkg::MIC_IDLE;
					nxt_pc  = vec_addr_i; // see [R21]
					nxt_ent.pc_load = 1'b1; // see [R22]
				end
			end
			default: begin
				nxt_st = mic_pkg::MIC_IDLE;
			end
		endcase
	end

	// Entry sequencer registers
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			st_ff   <= mic_pkg::MIC_IDLE;
			cnt_ff  <= 5'h00;
			win_ff  <= 4'h0;
			alvl_ff <= `MIC_LVL_OFF;
			trap_ff <= 1'b0;
			tmp_ff  <= 8'h00;
			ent_ff  <= '0;
			num_ff  <= 6'h00;
			flg_ff  <= 8'h00;
			ipl_ff  <= `MIC_LVL_OFF;
			pc_ff   <= 20'h00000;
		end else begin
			st_ff   <= nxt_st;
			cnt_ff  <= nxt_cnt;
			win_ff  <= nxt_win;
			alvl_ff <= nxt_alvl;
			trap_ff <= nxt_trap;
			tmp_ff  <= nxt_tmp;
			ent_ff  <= nxt_ent;
			num_ff  <= nxt_num;
			flg_ff  <= nxt_flg;
			ipl_ff  <= nxt_ipl;
			pc_ff   <= nxt_pc;
		end
	end

	assign entry_o      = ent_ff;
	assign fetch_addr_o = `MIC_INFO_ADDR;
	assign vec_num_o    = num_ff;
	assign flag_o       = flg_ff;
	assign ipl_o        = ipl_ff;
	assign pc_o         = pc_ff;
	assign busy_o       = (st_ff != mic_pkg::MIC_IDLE);

	// Entry runs twenty cycles from fetch strobe to PC load
	chk_seq_length: assert property (@(posedge clk_sys_i) // see [R22]
		disable iff (reset_i)
		entry_o.fetch |-> ##19 entry_o.pc_load)
		else $error("entry sequence length wrong");
	// Flags pushed before the program counter
	chk_push_order: assert property (@(posedge clk_sys_i) // see [R17]
		disable iff (reset_i)
		entry_o.push_flg |-> ##4 entry_o.push_pc)
		else $error("push order wrong");
	// Pushed flags equal the copy taken at acceptance
	chk_saved_flags: assert property (@(posedge clk_sys_i) // see [R17]
		disable iff (reset_i)
		$rose(busy_o) |-> ##6 (flag_o == $past(flag_i, 7)))
		else $error("saved flags differ");
	// No non-trap acceptance without the global enable
	chk_enable_gate: assert property (@(posedge clk_sys_i) // see [R11]
		disable iff (reset_i)
		(accept && !trap_i) |-> flag_i[`MIC_FLG_I])
		else $error("accepted with enable clear");
	// Non-trap accepted level must exceed the mask level
	chk_mask_level: assert property (@(posedge clk_sys_i) // see [R12]
		disable iff (reset_i)
		(accept && !trap_i) |=> (alvl_ff > $past(ipl_i)))
		else $error("accepted at or below mask");
	// Flag update clears enable and single step, loads level
	chk_flag_clear: assert property (@(posedge clk_sys_i) // see [R18] [R20]
		disable iff (reset_i)
		entry_o.flg_upd |-> (!flag_o[`MIC_FLG_I] && !flag_o[`MIC_FLG_D]
			&& ipl_o == alvl_ff))
		else $error("flag update wrong");
	// High traps keep the stack select flag
	chk_trap_ustay: assert property (@(posedge clk_sys_i) // see [R19]
		disable iff (reset_i)
		(entry_o.flg_upd && trap_ff && num_ff >= `MIC_TRAP_LO)
		|-> (flag_o[`MIC_FLG_U] == tmp_ff[`MIC_FLG_U]))
		else $error("stack select changed by trap");
	// Accepted pin source loses its pending flag
	chk_ack_clear: assert property (@(posedge clk_sys_i) // see [R3] [R16]
		disable iff (reset_i)
		(entry_o.fetch && !trap_ff && IS_PIN[win_ff]
			&& !$past(evt_w[best]))
		|-> !pend_w[win_ff])
		else $error("pending not cleared on entry");
	// Bus answer is always OKAY and reads stall one cycle
	chk_read_wait: assert property (@(posedge clk_sys_i)
		disable iff (reset_i)
		(addr_ok && !hwrite_i) |=> (!hreadyout_o && !hresp_o)
		##1 hreadyout_o)
		else $error("read wait state wrong");
endmodule

// File: src/mic_params.svh
// Constants for the maskable interrupt control block
// Contract
// [R1] Level 0 disables, 7 is highest priority
// [R2] Source request sets its pending flag
// [R3] Acknowledge and vector branch clear pending flag
// [R4] Software clears pending by writing 0 only
// [R5] Multi-source pending flags are read-only
// [R6] Pin edge select: 0 falling, 1 rising
// [R7] Software keeps edge select 0 for both-edge mode
// [R8] Rewriting edge select may set pending flag
// [R9] Software rewrites control only while source idle
// [R10] Accept needs enable, pending, level above mask
// [R11] Global enable 0 blocks all maskable requests
// [R12] Mask level n passes only levels above n
// [R13] Enable, pending, level, mask stay independent
// [R14] Evaluate at instruction end, enter next cycle
// [R15] String and repeat ops suspend for entry
// [R16] First step reads info at 00000h, clears pending
// [R17] Save flags to temp, push it then PC
// [R18] Entry clears enable, single-step and stack flags
// [R19] Traps 32 to 63 keep stack select flag
// [R20] After saving, mask level takes accepted level
// [R21] Last step loads PC from the vector
// [R22] Entry sequence lasts 20 cycles
// [R23] Equal levels resolved by fixed hardware order
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

`define MIC_NSRC        12
`define MIC_NPIN        5
// Register indices; byte address is four times the index
`define MIC_IDX_FLASH   8'h41
`define MIC_IDX_PIN4    8'h46
`define MIC_IDX_PWM     8'h47
`define MIC_IDX_SER0    8'h4f
`define MIC_IDX_PIN2    8'h55
`define MIC_IDX_PIN1    8'h59
`define MIC_IDX_PIN3    8'h5a
`define MIC_IDX_PIN0    8'h5d
`define MIC_IDX_SENSOR  8'h6a
`define MIC_IDX_SER1    8'h78
`define MIC_IDX_SER2    8'h79
`define MIC_IDX_SER3    8'h7a
// Control register fields
`define MIC_LVL_MSB     2
`define MIC_PEND_BIT    3
`define MIC_EDGE_BIT    4
`define MIC_LVL_OFF     3'h0
`define MIC_LVL_MAX     3'h7
// Flag register bit positions
`define MIC_FLG_D       1
`define MIC_FLG_I       6
`define MIC_FLG_U       7
// Entry sequence timing in cycles after the fetch strobe
`define MIC_SEQ_LEN     5'h14
`define MIC_STEP_PUSHF  5'h06
`define MIC_STEP_PUSHPC 5'h0a
`define MIC_STEP_FLAGS  5'h0e
`define MIC_STEP_LOADPC 5'h13
`define MIC_INFO_ADDR   20'h00000
`define MIC_TRAP_LO     6'h20
// AHB transfer type and unmapped read value
`define MIC_HTRANS_NSEQ 2'h2
`define MIC_RD_ZERO     32'h00000000
`endif

// File: src/mic_pkg.sv
// Types for the maskable interrupt control block
package mic_pkg;
	// Entry sequencer states, Gray coded along the path
	typedef enum logic [1:0] {
		MIC_IDLE  = 2'h0,
		MIC_FETCH = 2'h1,
		MIC_SAVE  = 2'h3,
		MIC_LOAD  = 2'h2
	} mic_state_e;

	// Strobes toward the CPU core during entry
	typedef struct packed {
		logic fetch;     // Read of the information word
		logic push_flg;  // Push of the saved flags
		logic push_pc;   // Push of the program counter
		logic flg_upd;   // Flags and mask level take new values
		logic pc_load;   // Program counter takes the vector
	} mic_entry_s;
endpackage

// File: src/mic_src_ctrl.sv
// One interrupt source: control register, pending flag, pin edge logic
`timescale 1ns/1ps
`include "mic_params.svh"
module mic_src_ctrl #(
	parameter bit IS_PIN = 1'b0       // External pin source
) (
	input  wire logic       clk_sys_i,  // System clock
	input  wire logic       reset_i,    // Synchronous reset
	input  wire logic       req_i,      // Multi-source request level
	input  wire logic       pin_i,      // Raw pin, async
	input  wire logic       both_i,     // Both-edge select
	input  wire logic       wr_i,       // Register write strobe
	input  wire logic [7:0] wdata_i,    // Register write data
	input  wire logic       ack_clr_i,  // Entry clears pending
	output logic      [7:0] ctrl_o,     // Register read value
	output logic      [2:0] level_o,    // Priority level
	output logic            pend_o,     // Pending flag
	output logic            evt_o       // Request event this cycle
);
	logic [2:0] lvl_ff,  nxt_lvl;   // Priority level
	logic       pend_ff, nxt_pend;  // Pending flag
	logic       edge_ff, nxt_edge;  // Edge sense select
	logic [2:0] sync_ff, nxt_sync;  // Pin synchroniser
	logic       pin_ff,  nxt_pin;   // Accepted pin level
	logic       rise, fall, pol_evt;

	// Next values of the control state
	always_comb begin
		nxt_sync = {sync_ff[1:0], pin_i};
		nxt_pin  = pin_ff;
		// A change counts once stages two and three agree
		if (sync_ff[2] == sync_ff[1]) begin
			nxt_pin = sync_ff[2];
		end
		rise = IS_PIN && !pin_ff && nxt_pin;
		fall = IS_PIN && pin_ff && !nxt_pin;
		// Polarity change with pin already at new edge's end level
		pol_evt = IS_PIN && wr_i
			&& (wdata_i[`MIC_EDGE_BIT] != edge_ff)
			&& (pin_ff == wdata_i[`MIC_EDGE_BIT]); // see [R8]
		if (IS_PIN) begin
			evt_o = both_i ? (rise || fall)
				: (edge_ff ? rise : fall); // see [R6]
		end else begin
			evt_o = 1'b0;
		end
		nxt_lvl  = wr_i ? wdata_i[`MIC_LVL_MSB:0] : lvl_ff; // see [R1]
		nxt_edge = (IS_PIN && wr_i) ? wdata_i[`MIC_EDGE_BIT] : edge_ff;
		if (!IS_PIN) begin
			// Owned by the source, read-only here
			nxt_pend = req_i; // see [R5]
		end else if (evt_o || pol_evt) begin
			// Set wins over any clear
			nxt_pend = 1'b1; // see [R2]
		end else if (wr_i && !wdata_i[`MIC_PEND_BIT]) begin
			nxt_pend = 1'b0; // see [R4]
		end else if (ack_clr_i) begin
			nxt_pend = 1'b0; // see [R3]
		end else begin
			nxt_pend = pend_ff;
		end
	end

	// Register the control state
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			lvl_ff  <= `MIC_LVL_OFF;
			pend_ff <= 1'b0;
			edge_ff <= 1'b0;
			// Pins idle high: no false edge once reset ends
			sync_ff <= 3'h7;
			pin_ff  <= 1'b1;
		end else begin
			lvl_ff  <= nxt_lvl;
			pend_ff <= nxt_pend;
			edge_ff <= nxt_edge;
			sync_ff <= nxt_sync;
			pin_ff  <= nxt_pin;
		end
	end

	assign level_o = lvl_ff;
	assign pend_o  = pend_ff;
	assign ctrl_o  = {3'h0, IS_PIN ? edge_ff : 1'b0, pend_ff, lvl_ff};

	// Writing 1 to pending never sets it by itself
	chk_pend_no_w1: assert property (@(posedge clk_sys_i) // see [R4]
		disable iff (reset_i)
		(IS_PIN && wr_i && !pend_ff && !evt_o && !pol_evt)
		|=> !pend_ff)
		else $error("pending set by a software write");
endmodule

// File: tb/mic_cpu_model.sv
// Behavioural CPU core that feeds and follows the interrupt entry sequence
`timescale 1ns/1ps
module mic_cpu_model (
	input  wire logic        clk_sys_i,   // System clock
	input  wire logic        reset_i,     // Synchronous reset
	input  mic_pkg::mic_entry_s entry_i,  // Entry strobes
	input  wire logic [7:0]  flag_i,      // New flags from the block
	input  wire logic [2:0]  ipl_i,       // New mask level from the block
	input  wire logic [5:0]  num_i,       // Accepted interrupt number
	input  wire logic        set_i,       // Bench loads flags and mask
	input  wire logic [7:0]  set_flag_i,  // Flags to load
	input  wire logic [2:0]  set_ipl_i,   // Mask level to load
	output logic             done_o,      // Instruction boundary pulse
	output logic             susp_o,      // Suspendable op in progress
	output logic      [7:0]  flag_o,      // Flag register
	output logic      [2:0]  ipl_o,       // Mask level
	output logic      [19:0] vec_o        // Routine address from table
);
	logic [1:0] cnt_ff;  // Cycle within the current instruction

	// A boundary every fourth cycle, a suspendable op in between
	assign done_o = (cnt_ff == 2'h3);
	assign susp_o = (cnt_ff == 2'h1);

	// Flag register the block copies; changed by bench or entry update
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cnt_ff <= 2'h0;
			flag_o <= 8'h00;
			ipl_o  <= 3'h0;
			vec_o  <= 20'h00000;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
			if (set_i) begin
				flag_o <= set_flag_i;
				ipl_o  <= set_ipl_i;
			end else if (entry_i.flg_upd) begin
				flag_o <= flag_i;
				ipl_o  <= ipl_i;
			end
			// Vector table: one word per number above a fixed base
			if (entry_i.fetch) begin
				vec_o <= 20'h0c000 + {12'h000, num_i, 2'b00};
			end
		end
	end
endmodule

// File: tb/tb_maskable_interrupt_control.sv
// Self-checking bench for the maskable interrupt control block
`timescale 1ns/1ps
`include "mic_params.svh"
module tb_maskable_interrupt_control;
	logic               clk_sys_i;    // System clock
	logic               reset_i;      // Synchronous reset
	logic               hsel_i;       // Slave select
	logic        [31:0] haddr_i;      // Byte address
	logic        [1:0]  htrans_i;     // Transfer type
	logic               hwrite_i;     // Write not read
	logic        [31:0] hwdata_i;     // Write data
	logic               hreadyout_o;  // Slave ready, also bus ready
	logic        [31:0] hrdata_o;     // Read data
	logic               hresp_o;      // Response
	logic        [4:0]  pin_i;        // External pins, idle high
	logic        [6:0]  multi_req_i;  // Multi-source requests
	logic        [4:0]  both_edge;    // Both-edge select per pin
	logic               trap_i;       // Software trap request
	logic        [5:0]  trap_num_i;   // Trap number
	logic               set_i;        // Load CPU flags
	logic        [7:0]  set_flag;     // Flags to load
	logic        [2:0]  set_ipl;      // Mask to load
	logic               done_w;       // Instruction boundary
	logic               susp_w;       // Suspendable op
	logic        [7:0]  flag_w;       // CPU flags
	logic        [2:0]  ipl_w;        // CPU mask
	logic        [19:0] vec_w;        // Routine address
	mic_pkg::mic_entry_s entry_o;     // Entry strobes
	logic        [19:0] fetch_addr_o; // Information address
	logic        [5:0]  vec_num_o;    // Accepted number
	logic        [7:0]  flag_o;       // Flags pushed or updated
	logic        [2:0]  ipl_o;        // New mask
	logic        [19:0] pc_o;         // New program counter
	logic               busy_o;       // Entry running
	logic        [7:0]  idx [12];     // Register indices in map order
	logic        [2:0]  lvl;          // Random level
	int                 seed;         // Random seed
	int                 miscompares;  // Mismatch count
	int                 n_checks;     // Comparison count

	mic_top mic_top_inst (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
		.hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .hresp_o(hresp_o),
		.pin_i(pin_i), .both_edge_i(both_edge),
		.multi_req_i(multi_req_i), .instr_done_i(done_w),
		.suspend_ok_i(susp_w), .flag_i(flag_w), .ipl_i(ipl_w),
		.trap_i(trap_i), .trap_num_i(trap_num_i), .vec_addr_i(vec_w),
		.entry_o(entry_o), .fetch_addr_o(fetch_addr_o),
		.vec_num_o(vec_num_o), .flag_o(flag_o), .ipl_o(ipl_o),
		.pc_o(pc_o), .busy_o(busy_o));

	mic_cpu_model mic_cpu_model_inst (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .entry_i(entry_o),
		.flag_i(flag_o), .ipl_i(ipl_o), .num_i(vec_num_o),
		.set_i(set_i), .set_flag_i(set_flag), .set_ipl_i(set_ipl),
		.done_o(done_w), .susp_o(susp_w), .flag_o(flag_w),
		.ipl_o(ipl_w), .vec_o(vec_w));

	// Free-running 40 MHz clock
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	// One comparison, counted, reported on mismatch
	task check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask

	// Wait for the slave to be ready, bounded
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 20);
		if (n >= 20) check("hready", 32'h1, 32'h0);
	endtask

	// One single-word transfer: address phase, then data phase
	task bus(input logic wr, input logic [7:0] ix, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel_i   <= 1'b1;
		haddr_i  <= {22'h000000, ix, 2'b00};
		htrans_i <= `MIC_HTRANS_NSEQ;
		hwrite_i <= wr;
		wait_ready();
		hsel_i   <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		wait_ready();
		rd = hrdata_o;
	endtask

	// Register write of the meaningful byte
	task wr_reg(input logic [7:0] ix, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, ix, {24'h000000, d}, r);
	endtask

	// Register read compared with the expected byte, upper bits zero
	task rd_chk(input logic [7:0] ix, input logic [7:0] e);
		logic [31:0] r;
		bus(1'b0, ix, 32'h00000000, r);
		check("ctrl register", {24'h000000, e}, r);
	endtask

	// Load the CPU flags and mask level, let them settle
	task set_cpu(input logic [7:0] f, input logic [2:0] l);
		set_i    <= 1'b1;
		set_flag <= f;
		set_ipl  <= l;
		@(posedge clk_sys_i);
		set_i    <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	// No entry may start for n cycles
	task no_entry(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge clk_sys_i);
			if (entry_o.fetch !== 1'b0) seen = 1'b1;
		end
		check("no entry", 32'h0, 32'(seen));
	endtask

	// Whole entry sequence checked cycle by cycle from the fetch
	task entry(input logic [5:0] num, input logic [7:0] sav,
		input logic [7:0] nf, input logic [2:0] nl);
		int k;
		logic [4:0] e;
		k = 0;
		while (entry_o.fetch !== 1'b1 && k < 40) begin
			@(posedge clk_sys_i);
			k++;
		end
		trap_i <= 1'b0;
		for (k = 0; k < 20; k++) begin
			if (k > 0) @(posedge clk_sys_i);
			e = 5'h00;
			if (k == 0) e = 5'h10;
			if (k == `MIC_STEP_PUSHF) e = 5'h08;
			if (k == `MIC_STEP_PUSHPC) e = 5'h04;
			if (k == `MIC_STEP_FLAGS) e = 5'h02;
			if (k == `MIC_STEP_LOADPC) e = 5'h01;
			check("strobes", 32'(e), 32'(entry_o));
			check("busy", 32'(k < `MIC_STEP_LOADPC), 32'(busy_o));
			if (k == 0) begin
				check("vec num", 32'(num), 32'(vec_num_o));
				check("info addr", 32'h0, 32'(fetch_addr_o));
			end
			if (k == `MIC_STEP_PUSHF)
				check("saved flags", 32'(sav), 32'(flag_o));
			if (k == `MIC_STEP_FLAGS) begin
				check("new flags", 32'(nf), 32'(flag_o));
				check("new mask", 32'(nl), 32'(ipl_o));
			end
			if (k == `MIC_STEP_LOADPC)
				check("pc", 32'(20'h0c000 + {num, 2'b00}), 32'(pc_o));
		end
	endtask

	// Counts, verdict and end of run
	task summarize;
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		miscompares++;
		summarize();
	end

	// Main sequence
	initial begin
		seed = 32'hbcdbaed4;
		miscompares = 0;
		n_checks = 0;
		reset_i = 1'b1;
		hsel_i = 1'b0;
		haddr_i = 32'h00000000;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hwdata_i = 32'h00000000;
		pin_i = 5'h1f;
		both_edge = 5'h00;
		multi_req_i = 7'h00;
		trap_i = 1'b0;
		trap_num_i = 6'h28;
		set_i = 1'b0;
		set_flag = 8'h00;
		set_ipl = 3'h0;
		idx = '{`MIC_IDX_FLASH, `MIC_IDX_PIN4, `MIC_IDX_PWM, `MIC_IDX_SER0,
			`MIC_IDX_PIN2, `MIC_IDX_PIN1, `MIC_IDX_PIN3, `MIC_IDX_PIN0,
			`MIC_IDX_SENSOR, `MIC_IDX_SER1, `MIC_IDX_SER2, `MIC_IDX_SER3};
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(posedge clk_sys_i);
		check("resp", 32'h0, 32'(hresp_o));
		// Reset values, then an unmapped place
		foreach (idx[i]) rd_chk(idx[i], 8'h00);
		rd_chk(8'h40, 8'h00);
		// Random levels read back; pins idle, so nothing pends
		foreach (idx[i]) begin
			lvl = 3'($random(seed));
			wr_reg(idx[i], {5'h00, lvl});
			rd_chk(idx[i], {5'h00, lvl});
		end
		// Pin 0 falling edge sets pending; a written 1 is ignored
		wr_reg(`MIC_IDX_PIN0, 8'h05);
		pin_i[0] <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		rd_chk(`MIC_IDX_PIN0, 8'h0d);
		wr_reg(`MIC_IDX_PIN0, 8'h0d);
		rd_chk(`MIC_IDX_PIN0, 8'h0d);
		wr_reg(`MIC_IDX_PIN0, 8'h05);
		rd_chk(`MIC_IDX_PIN0, 8'h05);
		// Edge select rewrites: to rising with pin low, back to falling
		wr_reg(`MIC_IDX_PIN0, 8'h15);
		rd_chk(`MIC_IDX_PIN0, 8'h15);
		wr_reg(`MIC_IDX_PIN0, 8'h05);
		rd_chk(`MIC_IDX_PIN0, 8'h0d);
		wr_reg(`MIC_IDX_PIN0, 8'h05);
		wr_reg(`MIC_IDX_PIN0, 8'h15);
		pin_i[0] <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		rd_chk(`MIC_IDX_PIN0, 8'h1d);
		// Acceptance gates: enable off, mask 7, mask equal, then pass
		set_cpu(8'h83, 3'h0);
		no_entry(30);
		set_cpu(8'hc3, 3'h7);
		no_entry(30);
		set_cpu(8'hc3, 3'h5);
		no_entry(30);
		set_cpu(8'hc3, 3'h4);
		entry(6'h1d, 8'hc3, 8'h01, 3'h5);
		rd_chk(`MIC_IDX_PIN0, 8'h15);
		// Both-edge mode on pin 0, edge select left at falling
		both_edge <= 5'h01;
		wr_reg(`MIC_IDX_PIN0, 8'h01);
		pin_i[0] <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		rd_chk(`MIC_IDX_PIN0, 8'h09);
		wr_reg(`MIC_IDX_PIN0, 8'h01);
		pin_i[0] <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		rd_chk(`MIC_IDX_PIN0, 8'h09);
		// Trap above 31 keeps stack select and mask level
		set_cpu(8'h83, 3'h5);
		trap_i <= 1'b1;
		entry(6'h28, 8'h83, 8'h81, 3'h5);
		// Multi-source pending is read-only and follows its request
		multi_req_i <= 7'h18;
		wr_reg(`MIC_IDX_SENSOR, 8'h04);
		wr_reg(`MIC_IDX_SER1, 8'h04);
		rd_chk(`MIC_IDX_SENSOR, 8'h0c);
		wr_reg(`MIC_IDX_SENSOR, 8'h04);
		rd_chk(`MIC_IDX_SENSOR, 8'h0c);
		// Equal levels: fixed order picks the sensor first
		set_cpu(8'hc3, 3'h0);
		entry(6'h2a, 8'hc3, 8'h01, 3'h4);
		multi_req_i <= 7'h10;
		repeat (2) @(posedge clk_sys_i);
		set_cpu(8'hc3, 3'h0);
		entry(6'h38, 8'hc3, 8'h01, 3'h4);
		multi_req_i <= 7'h00;
		repeat (4) @(posedge clk_sys_i);
		summarize();
	end
endmodule
